//--- include/frt_consts.svh
// What this block does
// - Pin D edge captures counter unless buffered
// - Buffered mode: pin D sets flag only
// - Buffered flag D raises enabled interrupt
// - Counter equal compare A sets flag A
// - Counter equal compare B sets flag B
// - Counter wrap to zero sets overflow flag, except when Clear-on-match-A zeroes it at match
// - Clear-on-match-A bit zeroes counter at match
// - Flags clear only by read-one-then-write-zero
// - Writing one never sets any flag
// - Capture flag C clears by read-then-zero
// - Overflow flag clears by read-then-zero
// - Edge select D: 0 falling, 1 rising
// - Buffer B moves old capture B into D
`ifndef FRT_CONSTS_SVH
`define FRT_CONSTS_SVH
`define ADDR_STATUS 8'h00
`define ADDR_CONTROL 8'h04
`define ADDR_COMPARE_A 8'h08
`define ADDR_COMPARE_B 8'h0C
`define ADDR_CAPTURE_B 8'h10
`define ADDR_CAPTURE_D 8'h14
`define ADDR_COUNTER 8'h18
`define ADDR_IRQ_MASK 8'h1C
`define ADDR_IRQ_STATUS 8'h20
`define BIT_FLAG_C 5
`define BIT_FLAG_D 4
`define BIT_FLAG_A 3
`define BIT_FLAG_B 2
`define BIT_OVF 1
`define BIT_CLR_A 0
`define CTL_EDGE_B 0
`define CTL_EDGE_C 1
`define CTL_EDGE_D 2
`define CTL_BUF_B 3
`define CTL_IRQ_D 4
`define FLAG_MASK 8'h3E
`define COUNTER_MAX 16'hFFFF
`define COUNTER_ZERO 16'h0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

//--- include/frt_pkg.sv
`default_nettype none
package frt_pkg;
    typedef struct packed {
        logic flag_c;
        logic flag_d;
        logic flag_a;
        logic flag_b;
        logic ovf;
    } events_s;
    typedef enum logic [2:0] {
        WR_IDLE = 3'b001,
        WR_RESP = 3'b010,
        WR_HOLD = 3'b100
    } wr_state_e;
endpackage
`default_nettype wire

//--- design/pin_edge_detect.sv
`default_nettype none
module pin_edge_detect (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic pin,
    input wire logic rising,
    output logic edge_seen
);
    logic sync1, sync2, prev;
    logic next_sync1, next_sync2, next_prev;
    always_comb begin
        next_sync1 = pin;
        next_sync2 = sync1;
        next_prev = sync2;
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            prev <= 1'b0;
        end else begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            prev <= next_prev;
        end
    end
    // Polarity 1 watches rising, 0 falling.
    assign edge_seen = rising ? (sync2 & ~prev) : (~sync2 & prev);
endmodule
`default_nettype wire

//--- design/flag_cell.sv
`default_nettype none
module flag_cell (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic set,
    input wire logic read_seen,
    input wire logic write_zero,
    output logic flag
);
    logic armed;
    logic next_flag, next_armed;
    always_comb begin
        next_flag = flag;
        next_armed = armed;
        if (read_seen && flag) begin
            next_armed = 1'b1;
        end
        // Clear needs an earlier read of one.
        if (write_zero && armed) begin
            next_flag = 1'b0;
            next_armed = 1'b0;
        end
        // A set in the same cycle wins.
        if (set) begin
            next_flag = 1'b1;
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flag <= 1'b0;
            armed <= 1'b0;
        end else begin
            flag <= next_flag;
            armed <= next_armed;
        end
    end
endmodule
`default_nettype wire

//--- design/frt_flags.sv
`include "frt_consts.svh"
`default_nettype none
module frt_flags #(
    parameter int WIDTH = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic capture_pin_b,
    input wire logic capture_pin_c,
    input wire logic capture_pin_d,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////
    logic [WIDTH-1:0] free_running_counter, next_counter;
    logic [WIDTH-1:0] compare_reg_a, next_compare_a;
    logic [WIDTH-1:0] compare_reg_b, next_compare_b;
    logic [WIDTH-1:0] capture_reg_b, next_capture_b;
    logic [WIDTH-1:0] capture_reg_d, next_capture_d;
    logic [4:0] control, next_control;
    logic clear_on_match_a, next_clear_a;
    logic [4:0] irq_mask, next_irq_mask;
    logic [4:0] irq_status, next_irq_status;
    logic next_irq;
    frt_pkg::events_s ev, flags;
    logic edge_b, edge_c, edge_d;
    logic buffer_enable_b, edge_select_d, capture_d_irq_enable;
    logic match_a, match_b, wrap;
    logic status_read, status_wr_go;
    logic [7:0] wbyte;

    assign buffer_enable_b = control[`CTL_BUF_B];
    assign edge_select_d = control[`CTL_EDGE_D];
    assign capture_d_irq_enable = control[`CTL_IRQ_D];

    pin_edge_detect det_b (.clk(clk), .sys_rst(sys_rst),
        .pin(capture_pin_b), .rising(control[`CTL_EDGE_B]),
        .edge_seen(edge_b));
    pin_edge_detect det_c (.clk(clk), .sys_rst(sys_rst),
        .pin(capture_pin_c), .rising(control[`CTL_EDGE_C]),
        .edge_seen(edge_c));
    pin_edge_detect det_d (.clk(clk), .sys_rst(sys_rst),
        .pin(capture_pin_d), .rising(edge_select_d),
        .edge_seen(edge_d));

    ////////////////////////////////////////////////////////////////////////
    assign match_a = (free_running_counter == compare_reg_a);
    assign match_b = (free_running_counter == compare_reg_b);
    assign wrap = (free_running_counter == `COUNTER_MAX);

    always_comb begin
        ev.flag_c = edge_c;
        ev.flag_d = edge_d;
        ev.flag_a = match_a;
        ev.flag_b = match_b;
        ev.ovf = wrap && !(clear_on_match_a && match_a);
    end

    always_comb begin
        next_counter = free_running_counter + 1'b1;
        if (clear_on_match_a && match_a) begin
            next_counter = `COUNTER_ZERO;
        end
        next_capture_b = capture_reg_b;
        next_capture_d = capture_reg_d;
        if (edge_b) begin
            next_capture_b = free_running_counter;
            if (buffer_enable_b) begin
                next_capture_d = capture_reg_b;
            end
        end
        if (edge_d && !buffer_enable_b) begin
            next_capture_d = free_running_counter;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flag cells: arm on a status read, clear on a later zero write.
    assign status_read = s_axi_arvalid && s_axi_arready &&
        (s_axi_araddr == `ADDR_STATUS);

    flag_cell cell_c (.clk(clk), .sys_rst(sys_rst), .set(ev.flag_c),
        .read_seen(status_read),
        .write_zero(status_wr_go && !wbyte[`BIT_FLAG_C]),
        .flag(flags.flag_c));
    flag_cell cell_d (.clk(clk), .sys_rst(sys_rst), .set(ev.flag_d),
        .read_seen(status_read),
        .write_zero(status_wr_go && !wbyte[`BIT_FLAG_D]),
        .flag(flags.flag_d));
    flag_cell cell_a (.clk(clk), .sys_rst(sys_rst), .set(ev.flag_a),
        .read_seen(status_read),
        .write_zero(status_wr_go && !wbyte[`BIT_FLAG_A]),
        .flag(flags.flag_a));
    flag_cell cell_b (.clk(clk), .sys_rst(sys_rst), .set(ev.flag_b),
        .read_seen(status_read),
        .write_zero(status_wr_go && !wbyte[`BIT_FLAG_B]),
        .flag(flags.flag_b));
    flag_cell cell_o (.clk(clk), .sys_rst(sys_rst), .set(ev.ovf),
        .read_seen(status_read),
        .write_zero(status_wr_go && !wbyte[`BIT_OVF]),
        .flag(flags.ovf));

    ////////////////////////////////////////////////////////////////////////
    // Write channel: address and data may arrive in either order.
    frt_pkg::wr_state_e wr_state, next_wr_state;
    logic aw_held, w_held, next_aw_held, next_w_held;
    logic [7:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic next_awready, next_wready, next_bvalid;
    logic [1:0] next_bresp;
    logic wr_go;
    logic [7:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic wr_known;

    assign wa = aw_held ? aw_addr : s_axi_awaddr;
    assign wd = w_held ? w_data : s_axi_wdata;
    assign ws = w_held ? w_strb : s_axi_wstrb;
    assign wr_go = (wr_state == frt_pkg::WR_IDLE) &&
        (aw_held || (s_axi_awvalid && s_axi_awready)) &&
        (w_held || (s_axi_wvalid && s_axi_wready));
    assign wbyte = ws[0] ? wd[7:0] : 8'hFF;
    assign status_wr_go = wr_go && (wa == `ADDR_STATUS);

    always_comb begin
        wr_known = (wa == `ADDR_STATUS) || (wa == `ADDR_CONTROL) ||
            (wa == `ADDR_COMPARE_A) || (wa == `ADDR_COMPARE_B) ||
            (wa == `ADDR_CAPTURE_B) || (wa == `ADDR_CAPTURE_D) ||
            (wa == `ADDR_COUNTER) || (wa == `ADDR_IRQ_MASK) ||
            (wa == `ADDR_IRQ_STATUS);
    end

    always_comb begin
        next_wr_state = wr_state;
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_awready = s_axi_awready;
        next_wready = s_axi_wready;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        case (wr_state)
            frt_pkg::WR_IDLE: begin
                if (s_axi_awvalid && s_axi_awready) begin
                    next_aw_held = 1'b1;
                    next_aw_addr = s_axi_awaddr;
                    next_awready = 1'b0;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    next_w_held = 1'b1;
                    next_w_data = s_axi_wdata;
                    next_w_strb = s_axi_wstrb;
                    next_wready = 1'b0;
                end
                if (wr_go) begin
                    next_aw_held = 1'b0;
                    next_w_held = 1'b0;
                    next_awready = 1'b0;
                    next_wready = 1'b0;
                    next_bvalid = 1'b1;
                    next_bresp = wr_known ? `RESP_OKAY : `RESP_SLVERR;
                    next_wr_state = frt_pkg::WR_RESP;
                end
            end
            frt_pkg::WR_RESP: begin
                if (s_axi_bready) begin
                    next_bvalid = 1'b0;
                    next_wr_state = frt_pkg::WR_HOLD;
                end
            end
            frt_pkg::WR_HOLD: begin
                next_awready = 1'b1;
                next_wready = 1'b1;
                next_wr_state = frt_pkg::WR_IDLE;
            end
            default: begin
                next_wr_state = frt_pkg::WR_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Register updates from software writes.
    always_comb begin
        next_control = control;
        next_clear_a = clear_on_match_a;
        next_compare_a = compare_reg_a;
        next_compare_b = compare_reg_b;
        next_irq_mask = irq_mask;
        next_irq_status = irq_status | ev;
        if (wr_go) begin
            if (wa == `ADDR_STATUS) begin
                if (ws[0]) begin
                    next_clear_a = wd[`BIT_CLR_A];
                end
            end else if (wa == `ADDR_CONTROL) begin
                if (ws[0]) begin
                    next_control = wd[4:0];
                end
            end else if (wa == `ADDR_COMPARE_A) begin
                if (ws[0]) next_compare_a[7:0] = wd[7:0];
                if (ws[1]) next_compare_a[15:8] = wd[15:8];
            end else if (wa == `ADDR_COMPARE_B) begin
                if (ws[0]) next_compare_b[7:0] = wd[7:0];
                if (ws[1]) next_compare_b[15:8] = wd[15:8];
            end else if (wa == `ADDR_IRQ_MASK) begin
                if (ws[0]) next_irq_mask = wd[4:0];
            end else if (wa == `ADDR_IRQ_STATUS) begin
                if (ws[0]) begin
                    // Set wins over the write-one clear.
                    next_irq_status = (irq_status & ~wd[4:0]) | ev;
                end
            end
        end
    end

    logic [WIDTH-1:0] counter_final;
    always_comb begin
        counter_final = next_counter;
        if (wr_go && wa == `ADDR_COUNTER) begin
            if (ws[0]) counter_final[7:0] = wd[7:0];
            if (ws[1]) counter_final[15:8] = wd[15:8];
        end
    end

    // Capture D interrupts through irq_mask, and also directly in buffered mode when enabled.
    always_comb begin
        next_irq = |(irq_status & irq_mask) ||
            (flags.flag_d && buffer_enable_b && capture_d_irq_enable);
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel: one cycle from accept to data.
    logic [31:0] rd_word, next_rdata;
    logic [1:0] next_rresp;
    logic next_rvalid, next_arready;
    always_comb begin
        rd_word = 32'h0000_0000;
        next_rresp = `RESP_OKAY;
        if (s_axi_araddr == `ADDR_STATUS) begin
            rd_word[7:0] = {2'h0, flags, clear_on_match_a};
        end else if (s_axi_araddr == `ADDR_CONTROL) begin
            rd_word[4:0] = control;
        end else if (s_axi_araddr == `ADDR_COMPARE_A) begin
            rd_word[15:0] = compare_reg_a;
        end else if (s_axi_araddr == `ADDR_COMPARE_B) begin
            rd_word[15:0] = compare_reg_b;
        end else if (s_axi_araddr == `ADDR_CAPTURE_B) begin
            rd_word[15:0] = capture_reg_b;
        end else if (s_axi_araddr == `ADDR_CAPTURE_D) begin
            rd_word[15:0] = capture_reg_d;
        end else if (s_axi_araddr == `ADDR_COUNTER) begin
            rd_word[15:0] = free_running_counter;
        end else if (s_axi_araddr == `ADDR_IRQ_MASK) begin
            rd_word[4:0] = irq_mask;
        end else if (s_axi_araddr == `ADDR_IRQ_STATUS) begin
            rd_word[4:0] = irq_status;
        end else begin
            next_rresp = `RESP_SLVERR;
        end
        next_rdata = s_axi_rdata;
        next_rvalid = s_axi_rvalid;
        next_arready = s_axi_arready;
        if (s_axi_arvalid && s_axi_arready) begin
            next_rdata = rd_word;
            next_rvalid = 1'b1;
            next_arready = 1'b0;
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
            next_arready = 1'b1;
        end
        if (!(s_axi_arvalid && s_axi_arready)) begin
            next_rresp = s_axi_rresp;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            free_running_counter <= `COUNTER_ZERO;
            compare_reg_a <= 16'hFFFF;
            compare_reg_b <= 16'hFFFF;
            capture_reg_b <= 16'h0000;
            capture_reg_d <= 16'h0000;
            control <= 5'h00;
            clear_on_match_a <= 1'b0;
            irq_mask <= 5'h00;
            irq_status <= 5'h00;
            irq <= 1'b0;
            wr_state <= frt_pkg::WR_IDLE;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else begin
            free_running_counter <= counter_final;
            compare_reg_a <= next_compare_a;
            compare_reg_b <= next_compare_b;
            capture_reg_b <= next_capture_b;
            capture_reg_d <= next_capture_d;
            control <= next_control;
            clear_on_match_a <= next_clear_a;
            irq_mask <= next_irq_mask;
            irq_status <= next_irq_status;
            irq <= next_irq;
            wr_state <= next_wr_state;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end
endmodule
`default_nettype wire

//--- testbench/frt_flags_asserts.sv
`default_nettype none
module frt_flags_asserts (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic irq
);
    logic [7:0] aw_addr, next_aw_addr, ar_addr, next_ar_addr;
    logic [4:0] seen, next_seen;
    logic seen_ok, next_seen_ok, rd_stat;
    default clocking dcb @(posedge clk); endclocking
    default disable iff (sys_rst);
    function automatic logic bad(input logic [7:0] a);
        return a > 8'h20 || a[1:0] != 2'h0;
    endfunction
    ////////////////////////////////////////////////////////////////////////
    // Flags seen set at one status read must still be set at the next one
    // unless a status write came in between.
    assign rd_stat = s_axi_rvalid && s_axi_rready && ar_addr == 8'h00;
    always_comb begin
        next_aw_addr = aw_addr;
        next_ar_addr = ar_addr;
        next_seen = seen;
        next_seen_ok = seen_ok;
        if (s_axi_arvalid && s_axi_arready) next_ar_addr = s_axi_araddr;
        if (rd_stat) begin
            next_seen = s_axi_rdata[5:1];
            next_seen_ok = 1'b1;
        end
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_addr = s_axi_awaddr;
            next_seen_ok = next_seen_ok && s_axi_awaddr != 8'h00;
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            aw_addr <= 8'h00;
            ar_addr <= 8'h00;
            seen <= 5'h00;
            seen_ok <= 1'b0;
        end else begin
            aw_addr <= next_aw_addr;
            ar_addr <= next_ar_addr;
            seen <= next_seen;
            seen_ok <= next_seen_ok;
        end
    end
    sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_write_answer: assert property (s_wr_both |=> s_axi_bvalid)
        else $error("write not answered next cycle");
    a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_busy_refuses: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_write_resp_code: assert property (s_axi_bvalid
        |-> s_axi_bresp == (bad(aw_addr) ? 2'h2 : 2'h0))
        else $error("wrong write response code");
    a_read_resp_code: assert property (s_rd_take
        |=> s_axi_rvalid && s_axi_rresp == (bad(ar_addr) ? 2'h2 : 2'h0))
        else $error("read not answered or wrong code");
    a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_irq_after_reset: assert property ($fell(sys_rst) |-> !irq)
        else $error("interrupt high right after reset");
    a_flags_sticky: assert property (rd_stat && seen_ok
        |-> (s_axi_rdata[5:1] & seen) == seen)
        else $error("flag cleared without a status write");
endmodule
`default_nettype wire

//--- testbench/frt_flags_tb.sv
`include "frt_consts.svh"
`default_nettype none
module frt_flags_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, sys_rst, capture_pin_b, capture_pin_c, capture_pin_d;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdv, cap;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [15:0] seed, b, c0;
    int n_errors = 0, checks_done = 0, m_st = 0, m_arm = 0;
    frt_flags frt_flags_inst (
        .clk(clk), .sys_rst(sys_rst), .capture_pin_b(capture_pin_b),
        .capture_pin_c(capture_pin_c), .capture_pin_d(capture_pin_d),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .irq(irq)
    );
    always #12.5 clk = ~clk;
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
            if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
        end while (!(s_axi_bvalid && s_axi_bready) && n < 50);
        s_axi_bready <= 1'b0;
        resp = s_axi_bresp;
        if (n >= 50) chk(32'h0, 32'h1);
    endtask
    task automatic rd(input logic [7:0] a);
        int n = 0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
        end while (!(s_axi_rvalid && s_axi_rready) && n < 50);
        s_axi_rready <= 1'b0;
        rdv = s_axi_rdata;
        resp = s_axi_rresp;
        if (n >= 50) chk(32'h0, 32'h1);
    endtask
    // A status read arms the flags it sees set for a later clearing write.
    task automatic stc();
        rd(`ADDR_STATUS);
        m_arm = m_st & 32'h3E;
        chk(rdv, m_st);
    endtask
    task automatic stw(input logic [31:0] d);
        wr(`ADDR_STATUS, d);
        m_st = m_st & ~(m_arm & ~d & 32'h3E);
        m_arm = m_arm & d;
        m_st = (m_st & 32'h3E) | (d & 32'h1);
    endtask
    task automatic pins(input logic [2:0] v);
        @(posedge clk);
        {capture_pin_b, capture_pin_c, capture_pin_d} <= v;
        repeat (8) @(posedge clk);
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        $display("BAD at %0t: watchdog expired", $time);
        print_verdict();
    end
    initial begin
        clk = 1'b0;
        sys_rst = 1'b1;
        {capture_pin_b, capture_pin_c, capture_pin_d} = 3'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        seed = 16'h0021;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        stc();
        chk(32'(irq), 32'h0);
        rd(8'h40);
        chk(32'(resp), 32'h2);
        wr(8'h44, 32'hFFFF);
        chk(32'(resp), 32'h2);
        $display("test reset done");
        seed = lfsr(seed);
        b = (seed & 16'h3FFF) | 16'h4000;
        wr(`ADDR_COMPARE_A, 32'(b + 16'h001E));
        wr(`ADDR_COMPARE_B, 32'(b + 16'h003C));
        wr(`ADDR_COUNTER, 32'(b));
        stc();
        repeat (100) @(posedge clk);
        m_st = m_st | 32'h0C;
        stw(32'h0);
        stc();
        rd(`ADDR_COUNTER);
        chk(32'(rdv[15:0] > b + 16'h003C), 32'h1);
        stw(32'h3E);
        stc();
        stw(32'h0);
        stc();
        $display("test compare done");
        wr(`ADDR_COUNTER, 32'hFFF0);
        repeat (40) @(posedge clk);
        m_st = m_st | 32'h02;
        stc();
        stw(32'h3C);
        stc();
        wr(`ADDR_COMPARE_A, 32'h0100);
        stw(32'h3F);
        wr(`ADDR_COUNTER, 32'h00F0);
        repeat (300) @(posedge clk);
        rd(`ADDR_COUNTER);
        chk(32'(rdv[15:0] <= 16'h0100), 32'h1);
        m_st = m_st | 32'h08;
        wr(`ADDR_COMPARE_A, 32'h0);
        wr(`ADDR_COUNTER, 32'h0);
        stc();
        stw(32'h1);
        m_st = m_st | 32'h08;
        wr(`ADDR_COMPARE_A, 32'h8000);
        stc();
        stw(32'h3E);
        stc();
        stw(32'h0);
        stc();
        $display("test overflow done");
        wr(`ADDR_CONTROL, 32'h04);
        rd(`ADDR_COUNTER);
        c0 = rdv[15:0];
        pins(3'h1);
        m_st = m_st | 32'h10;
        stc();
        rd(`ADDR_CAPTURE_D);
        chk(32'(rdv[15:0] - c0 < 16'h0020), 32'h1);
        stw(32'h0);
        pins(3'h0);
        stc();
        wr(`ADDR_CONTROL, 32'h00);
        pins(3'h1);
        stc();
        pins(3'h0);
        m_st = m_st | 32'h10;
        stc();
        stw(32'h0);
        pins(3'h2);
        pins(3'h0);
        m_st = m_st | 32'h20;
        stw(32'h0);
        stc();
        stw(32'h0);
        stc();
        $display("test capture done");
        wr(`ADDR_CONTROL, 32'h18);
        rd(`ADDR_CAPTURE_D);
        cap = rdv;
        pins(3'h1);
        pins(3'h0);
        m_st = m_st | 32'h10;
        chk(32'(irq), 32'h1);
        stc();
        rd(`ADDR_CAPTURE_D);
        chk(rdv, cap);
        stc();
        stw(32'h0);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0);
        rd(`ADDR_CAPTURE_B);
        cap = rdv;
        pins(3'h4);
        pins(3'h0);
        rd(`ADDR_CAPTURE_D);
        chk(rdv, cap);
        $display("test buffer done");
        wr(`ADDR_IRQ_MASK, 32'h1F);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h1);
        rd(`ADDR_IRQ_STATUS);
        chk(rdv & 32'h1, 32'h1);
        wr(`ADDR_IRQ_STATUS, 32'h1F);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0);
        $display("test interrupt done");
        print_verdict();
    end
endmodule
bind frt_flags frt_flags_asserts frt_flags_asserts_inst (
    .clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq)
);
`default_nettype wire
